// *** core/ghpbc_boot_config.sv ***
// Purpose: boot strap capture, message override and port/power control
// Assumes: strap pins are asynchronous; message and status inputs are
//          synchronous to clock_in
// Notes:   backup copy lives on its own reset, the backup supply flag
`timescale 1ns/1ps

module ghpbc_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input  wire logic             clock_in,
    input  wire logic             nrst_in,
    input  wire logic             wr_valid_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  wr_ready_out,
    output logic                  rd_valid_out,
    output logic [WIDTH-1:0]      rd_data_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0]      count_reg, count_next;
    logic             push, pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two of at least 2");
    end

    // full and empty follow the count, so both stay honest under stalls
    always_comb begin
        push        = wr_valid_in && (count_reg != (AW+1)'(DEPTH));
        pop         = rd_ready_in && (count_reg != '0);
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // storage has no reset; only slots already written are ever read
    always_ff @(posedge clock_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr_data_in;
        end
    end

    assign wr_ready_out = (count_reg != (AW+1)'(DEPTH));
    assign rd_valid_out = (count_reg != '0);
    assign rd_data_out  = mem[rd_ptr_reg];
endmodule : ghpbc_fifo

module ghpbc_boot_config
    import ghpbc_pkg::*;
#(
    parameter int NUM_SECTIONS = 4,
    parameter int MSG_DEPTH    = 8,
    parameter int ECO_MIN_SATS = 4
) (
    input  wire logic                        clock_in,
    input  wire logic                        nrst_in,
    input  wire logic                        bckp_nrst_in,
    input  wire logic                        port_cfg_strap_lo_in,
    input  wire logic                        port_cfg_strap_hi_in,
    input  wire logic                        power_mode_strap_in,
    input  wire logic                        msg_valid_in,
    input  wire ghpbc_pkg::ghpbc_msg_t       msg_in,
    output logic                             msg_ready_out,
    input  wire logic                        fix_valid_in,
    input  wire logic [5:0]                  sats_tracked_in,
    input  wire logic [NUM_SECTIONS-1:0]     section_req_in,
    output ghpbc_pkg::ghpbc_cfg_t            cfg_out,
    output logic                             cfg_ready_out,
    output logic                             cfg_from_backup_out,
    output logic                             acq_engine_en_out,
    output logic [NUM_SECTIONS-1:0]          section_en_out,
    output logic [NUM_PORTS*NUM_PROTOS-1:0]  port_tx_en_out,
    output logic [NUM_PORTS*NUM_PROTOS-1:0]  port_rx_en_out,
    output logic                             usb_plus_line_pullup_out,
    output logic                             spi_bit_tick_out
);
    import ghpbc_pkg::*;

    typedef enum logic [1:0] {ST_SYNC, ST_CAPTURE, ST_RUN} ghpbc_state_t;

    if (NUM_SECTIONS < 1 || ECO_MIN_SATS < 1 || ECO_MIN_SATS > 63) begin : g_chk
        $error("section count or eco satellite threshold out of range");
    end

    ghpbc_state_t state_reg, state_next;
    logic [2:0]   sync1_reg, sync2_reg;
    logic [1:0]   wait_reg, wait_next;
    ghpbc_cfg_t   cfg_reg, cfg_next, bckp_cfg_reg, bckp_cfg_next;
    logic         bckp_valid_reg, bckp_valid_next;
    logic         from_bckp_reg, from_bckp_next;
    logic         acq_reg, acq_next;
    logic         ready_reg;
    logic [NUM_SECTIONS-1:0] sect_reg, sect_next;
    logic [NUM_PORTS*NUM_PROTOS-1:0] tx_reg, tx_next, rx_reg, rx_next;
    logic [9:0]   spi_cnt_reg, spi_cnt_next;
    logic         spi_tick_reg, spi_tick_next;
    logic         fifo_valid, fifo_ready, fifo_wr_ready;
    ghpbc_msg_t   fifo_msg;
    ghpbc_cfg_t   strap_cfg;

    // incoming messages queue here; draining waits for strap capture
    ghpbc_fifo #(.WIDTH($bits(ghpbc_msg_t)), .DEPTH(MSG_DEPTH)) u_fifo (
        .clock_in     (clock_in),
        .nrst_in      (nrst_in),
        .wr_valid_in  (msg_valid_in),
        .wr_data_in   (msg_in),
        .wr_ready_out (fifo_wr_ready),
        .rd_valid_out (fifo_valid),
        .rd_data_out  (fifo_msg),
        .rd_ready_in  (fifo_ready)
    );
    assign fifo_ready = (state_reg == ST_RUN);

    // straps are pins: two flops before anything reads them
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {power_mode_strap_in, port_cfg_strap_hi_in,
                          port_cfg_strap_lo_in};
            sync2_reg <= sync1_reg;
        end
    end

    // strap decode; reduced satellites-in-view set on the 4800 setting
    always_comb begin
        strap_cfg = CFG_RESET;
        unique case (sync2_reg[1:0])
            2'h3: begin
                strap_cfg.baud = BAUD_9600;
            end
            2'h2: begin
                strap_cfg.baud         = BAUD_38400;
                strap_cfg.usb_self_pwr = 1'b1;
            end
            2'h1: begin
                strap_cfg.baud   = BAUD_4800;
                strap_cfg.msgset = MSGSET_NMEA_REDUCED;
            end
            2'h0: begin
                strap_cfg.baud      = BAUD_57600;
                strap_cfg.proto_out = OUT_BIN;
                strap_cfg.msgset    = MSGSET_BIN_NAV;
            end
        endcase
        strap_cfg.pwr = sync2_reg[2] ? PWR_MAX_PERF : PWR_ECO;
    end

    // main sequence: wait for the synchroniser to fill, capture, then run
    always_comb begin
        state_next      = state_reg;
        wait_next       = wait_reg;
        cfg_next        = cfg_reg;
        from_bckp_next  = from_bckp_reg;
        bckp_cfg_next   = bckp_cfg_reg;
        bckp_valid_next = bckp_valid_reg;
        unique case (state_reg)
            ST_SYNC: begin
                wait_next = wait_reg + 1'b1;
                if (wait_reg == 2'(SYNC_STAGES - 1)) begin
                    state_next = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                // the only look at the straps; later pin activity is SPI
                state_next     = ST_RUN;
                cfg_next       = bckp_valid_reg ? bckp_cfg_reg
                                                : strap_cfg;
                from_bckp_next = bckp_valid_reg;
            end
            ST_RUN: begin
                if (fifo_valid) begin
                    unique case (fifo_msg.field)
                        FLD_PROTO_OUT:
                            cfg_next.proto_out = fifo_msg.value[2:0]
                                                 & OUT_LEGAL;
                        FLD_PROTO_IN:
                            cfg_next.proto_in = fifo_msg.value[2:0];
                        FLD_BAUD:
                            cfg_next.baud = fifo_msg.value;
                        FLD_MSGSET:
                            if (fifo_msg.value[1:0] != 2'h3) begin
                                cfg_next.msgset =
                                    ghpbc_msgset_t'(fifo_msg.value[1:0]);
                            end
                        FLD_USB_SELF:
                            cfg_next.usb_self_pwr = fifo_msg.value[0];
                        FLD_PWR:
                            if (fifo_msg.value[1:0] != 2'h3) begin
                                cfg_next.pwr =
                                    ghpbc_pwr_t'(fifo_msg.value[1:0]);
                            end
                        FLD_SPI_MASTER:
                            cfg_next.spi_master = fifo_msg.value[0];
                        FLD_DDC_MASTER:
                            cfg_next.ddc_master = fifo_msg.value[0];
                        FLD_USB_EN:
                            cfg_next.usb_en = fifo_msg.value[0];
                        FLD_SAVE: begin
                            bckp_cfg_next   = cfg_reg;
                            bckp_valid_next = 1'b1;
                        end
                        FLD_FORGET:
                            bckp_valid_next = 1'b0;
                        default: ;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg     <= ST_SYNC;
            wait_reg      <= 2'h0;
            cfg_reg       <= CFG_RESET;
            from_bckp_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            wait_reg      <= wait_next;
            cfg_reg       <= cfg_next;
            from_bckp_reg <= from_bckp_next;
        end
    end

    // backup copy is cleared when the backup supply drops; a forget message only clears its valid flag
    always_ff @(posedge clock_in or negedge bckp_nrst_in) begin
        if (!bckp_nrst_in) begin
            bckp_cfg_reg   <= CFG_RESET;
            bckp_valid_reg <= 1'b0;
        end else begin
            bckp_cfg_reg   <= bckp_cfg_next;
            bckp_valid_reg <= bckp_valid_next;
        end
    end

    // acquisition engine and receiver sections follow the power mode
    always_comb begin
        acq_next = 1'b1;
        if (cfg_reg.pwr != PWR_MAX_PERF && fix_valid_in
            && sats_tracked_in >= 6'(ECO_MIN_SATS)) begin
            acq_next = 1'b0;
        end
        if (state_reg != ST_RUN) begin
            acq_next = 1'b0;
        end
    end

    for (genvar s = 0; s < NUM_SECTIONS; s++) begin : g_sect
        assign sect_next[s] = (cfg_reg.pwr == PWR_SAVE)
                              ? section_req_in[s] : 1'b1;
    end

    // every protocol may run on every port; RTCM is never transmitted
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic on;
        assign on = (p != PORT_USB) || cfg_reg.usb_en;
        assign tx_next[p*NUM_PROTOS +: NUM_PROTOS] =
            on ? (cfg_reg.proto_out & OUT_LEGAL) : 3'h0;
        assign rx_next[p*NUM_PROTOS +: NUM_PROTOS] =
            on ? cfg_reg.proto_in : 3'h0;
    end

    // spi bit pacing: one tick per bit time keeps the rate legal
    always_comb begin
        spi_tick_next = 1'b0;
        spi_cnt_next  = spi_cnt_reg + 1'b1;
        if (spi_cnt_reg == 10'(SPI_BIT_CYCLES - 1)) begin
            spi_cnt_next  = 10'h000;
            spi_tick_next = 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acq_reg      <= 1'b0;
            sect_reg     <= '0;
            tx_reg       <= '0;
            rx_reg       <= '0;
            spi_cnt_reg  <= 10'h000;
            spi_tick_reg <= 1'b0;
            ready_reg    <= 1'b0;
        end else begin
            acq_reg      <= acq_next;
            sect_reg     <= sect_next;
            tx_reg       <= tx_next;
            rx_reg       <= rx_next;
            spi_cnt_reg  <= spi_cnt_next;
            spi_tick_reg <= spi_tick_next;
            ready_reg    <= (state_next == ST_RUN);
        end
    end

    assign msg_ready_out            = fifo_wr_ready;
    assign cfg_out                  = cfg_reg;
    assign cfg_ready_out            = ready_reg;
    assign cfg_from_backup_out      = from_bckp_reg;
    assign acq_engine_en_out        = acq_reg;
    assign section_en_out           = sect_reg;
    assign port_tx_en_out           = tx_reg;
    assign port_rx_en_out           = rx_reg;
    assign usb_plus_line_pullup_out = cfg_reg.usb_en;
    assign spi_bit_tick_out         = spi_tick_reg;
endmodule : ghpbc_boot_config

// *** core/ghpbc_pkg.sv ***
// Purpose: shared constants and types for the host port boot configuration
// Assumes: 100 MHz core clock
// Notes:   baud rates are carried as plain bit/s values
package ghpbc_pkg;
    localparam int CLK_HZ          = 100_000_000;
    localparam int SPI_MAX_BPS     = 100_000;
    // least bit time rounds up to whole cycles
    localparam int SPI_BIT_CYCLES  = (CLK_HZ + SPI_MAX_BPS - 1) / SPI_MAX_BPS;
    localparam int SYNC_STAGES     = 2;
    localparam int NUM_PORTS       = 3;
    localparam int NUM_PROTOS      = 3;
    localparam int PORT_UART       = 0;
    localparam int PORT_USB        = 1;
    localparam int PORT_DDC        = 2;
    localparam int PROTO_NMEA      = 0;
    localparam int PROTO_BIN       = 1;
    localparam int PROTO_RTCM      = 2;
    localparam logic [15:0] BAUD_4800  = 16'h12C0;
    localparam logic [15:0] BAUD_9600  = 16'h2580;
    localparam logic [15:0] BAUD_38400 = 16'h9600;
    localparam logic [15:0] BAUD_57600 = 16'hE100;
    localparam logic [2:0]  IN_ALL     = 3'h7;
    localparam logic [2:0]  OUT_NMEA   = 3'h1;
    localparam logic [2:0]  OUT_BIN    = 3'h2;
    localparam logic [2:0]  OUT_LEGAL  = 3'h3;

    typedef enum logic [1:0] {
        MSGSET_NMEA_FULL, MSGSET_NMEA_REDUCED, MSGSET_BIN_NAV
    } ghpbc_msgset_t;
    typedef enum logic [1:0] {
        PWR_MAX_PERF, PWR_ECO, PWR_SAVE
    } ghpbc_pwr_t;
    typedef enum logic [3:0] {
        FLD_PROTO_OUT, FLD_PROTO_IN, FLD_BAUD, FLD_MSGSET, FLD_USB_SELF,
        FLD_PWR, FLD_SPI_MASTER, FLD_DDC_MASTER, FLD_USB_EN, FLD_SAVE,
        FLD_FORGET
    } ghpbc_field_t;

    typedef struct packed {
        logic [2:0]    proto_in;
        logic [2:0]    proto_out;
        ghpbc_msgset_t msgset;
        logic [15:0]   baud;
        logic          usb_self_pwr;
        ghpbc_pwr_t    pwr;
        logic          spi_master;
        logic          ddc_master;
        logic          usb_en;
    } ghpbc_cfg_t;

    typedef struct packed {
        ghpbc_field_t field;
        logic [15:0]  value;
    } ghpbc_msg_t;

    localparam ghpbc_cfg_t CFG_RESET = '{IN_ALL, OUT_NMEA, MSGSET_NMEA_FULL,
        BAUD_9600, 1'b0, PWR_MAX_PERF, 1'b0, 1'b0, 1'b1};
endpackage : ghpbc_pkg

// *** testbench/ghpbc_boot_config_checker.sv ***
// Purpose: port-level checks of the boot configuration block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   tick spacing is counted in helper logic, not unrolled
`timescale 1ns/1ps
module ghpbc_boot_config_checker #(
    parameter int ECO_MIN_SATS = 4
) (
    input wire logic                  clock_in,
    input wire logic                  nrst_in,
    input wire logic                  power_mode_strap_in,
    input wire logic                  fix_valid_in,
    input wire logic [5:0]            sats_tracked_in,
    input wire ghpbc_pkg::ghpbc_cfg_t cfg_out,
    input wire logic                  cfg_ready_out,
    input wire logic                  cfg_from_backup_out,
    input wire logic                  acq_engine_en_out,
    input wire logic [8:0]            port_tx_en_out,
    input wire logic [8:0]            port_rx_en_out,
    input wire logic                  usb_plus_line_pullup_out,
    input wire logic                  spi_bit_tick_out
);
    import ghpbc_pkg::*;
    logic [9:0] gap_reg;
    logic [9:0] gap_next;
    logic       seen_reg;
    logic       seen_next;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    // cycles since the last tick; the first tick only arms the check
    always_comb begin
        gap_next  = spi_bit_tick_out ? 10'h000 : gap_reg + 10'h001;
        seen_next = seen_reg | spi_bit_tick_out;
    end
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gap_reg  <= 10'h000;
            seen_reg <= 1'b0;
        end else begin
            gap_reg  <= gap_next;
            seen_reg <= seen_next;
        end
    end

    a_pullup_usb_en: assert property (
        usb_plus_line_pullup_out == cfg_out.usb_en)
        else $error("usb pull-up differs from usb enable");
    a_rtcm_no_tx: assert property (
        {port_tx_en_out[8], port_tx_en_out[5], port_tx_en_out[2]} == 3'h0)
        else $error("correction protocol enabled for output");
    a_ports_same: assert property (
        port_tx_en_out[2:0] == port_tx_en_out[5:3]
        && port_tx_en_out[5:3] == port_tx_en_out[8:6]
        && port_rx_en_out[2:0] == port_rx_en_out[8:6])
        else $error("ports carry different protocol sets");
    a_tx_follows: assert property (
        cfg_ready_out && $past(cfg_ready_out) |->
        port_tx_en_out[2:0] == {1'b0, $past(cfg_out.proto_out[1:0])})
        else $error("output enables do not follow configuration");
    a_pwr_strap: assert property (
        $rose(cfg_ready_out) && !cfg_from_backup_out |->
        cfg_out.pwr == (power_mode_strap_in ? PWR_MAX_PERF : PWR_ECO))
        else $error("power mode does not match strap");
    a_maxperf_acq: assert property (
        cfg_ready_out && $past(cfg_ready_out)
        && $past(cfg_out.pwr) == PWR_MAX_PERF |-> acq_engine_en_out)
        else $error("acquisition off in max performance");
    a_eco_acq_off: assert property (
        cfg_ready_out && cfg_out.pwr == PWR_ECO && fix_valid_in
        && sats_tracked_in >= ECO_MIN_SATS |=> !acq_engine_en_out)
        else $error("acquisition still on after fix in eco");
    a_eco_acq_on: assert property (
        cfg_ready_out && cfg_out.pwr == PWR_ECO && !fix_valid_in
        |=> acq_engine_en_out)
        else $error("acquisition off without fix in eco");
    a_spi_tick_gap: assert property (
        seen_reg && spi_bit_tick_out |-> gap_reg == SPI_BIT_CYCLES - 1)
        else $error("bit tick spacing wrong");
endmodule : ghpbc_boot_config_checker

// *** testbench/ghpbc_host_model.sv ***
// Purpose: host that writes configuration words into the block
// Assumes: requests change at the falling clock edge
// Notes:   a released word is inverted so stale data never looks valid
`timescale 1ns/1ps
module ghpbc_host_model (
    input  wire logic             clock_in,
    input  wire logic             msg_ready_in,
    output logic                  msg_valid_out,
    output ghpbc_pkg::ghpbc_msg_t msg_out
);
    import ghpbc_pkg::*;
    initial begin
        msg_valid_out = 1'b0;
        msg_out       = '0;
    end
    // gap idles first; the word holds until taken at a rising edge
    task automatic send(input ghpbc_field_t f, input logic [15:0] v,
                        input int gap);
        // drop valid during the gap so a taken word is not pushed twice
        repeat (gap) begin
            @(negedge clock_in);
            msg_valid_out = 1'b0;
        end
        @(negedge clock_in);
        msg_valid_out = 1'b1;
        msg_out       = '{f, v};
        while (!msg_ready_in) @(negedge clock_in);
        @(posedge clock_in);
    endtask : send
    task automatic idle();
        @(negedge clock_in);
        msg_valid_out = 1'b0;
        msg_out       = ~msg_out;
    endtask : idle
endmodule : ghpbc_host_model

// *** testbench/tb.sv ***
// Purpose: self-checking bench of the boot configuration block
// Assumes: 100 MHz clock; straps steady around each reset release
// Notes:   expected configurations queue up, compared on each change
`timescale 1ns/1ps
module tb;
    import ghpbc_pkg::*;
    logic        clock_in = 1'b0;
    logic        nrst_in, bckp_nrst_in, s_lo, s_hi, s_pm, fix_valid;
    logic [5:0]  sats;
    logic [3:0]  sect_req, sect_en;
    logic [8:0]  tx_en, rx_en;
    logic [15:0] v;
    logic [31:0] seed;
    logic        msg_valid, msg_ready, cfg_ready, from_bk, acq;
    logic        prev_rdy = 1'b0;
    ghpbc_msg_t  msg;
    ghpbc_cfg_t  cfg, cur, saved, prev_cfg;
    ghpbc_cfg_t  exp_q[$];
    int          fail_count = 0, total_checks = 0, cycles = 0;

    always #5 clock_in = ~clock_in;

    ghpbc_boot_config dut (.clock_in, .nrst_in, .bckp_nrst_in,
        .port_cfg_strap_lo_in(s_lo), .port_cfg_strap_hi_in(s_hi),
        .power_mode_strap_in(s_pm), .msg_valid_in(msg_valid), .msg_in(msg),
        .msg_ready_out(msg_ready), .fix_valid_in(fix_valid),
        .sats_tracked_in(sats), .section_req_in(sect_req), .cfg_out(cfg),
        .cfg_ready_out(cfg_ready), .cfg_from_backup_out(from_bk),
        .acq_engine_en_out(acq), .section_en_out(sect_en),
        .port_tx_en_out(tx_en), .port_rx_en_out(rx_en),
        .usb_plus_line_pullup_out(), .spi_bit_tick_out());
    ghpbc_host_model host (.clock_in, .msg_ready_in(msg_ready),
        .msg_valid_out(msg_valid), .msg_out(msg));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // configuration the straps should select
    function automatic ghpbc_cfg_t strap_cfg(input logic hi, lo, pm);
        ghpbc_cfg_t c;
        c = CFG_RESET;
        c.proto_in     = IN_ALL;
        c.proto_out    = (hi | lo) ? OUT_NMEA : OUT_BIN;
        c.msgset       = hi ? MSGSET_NMEA_FULL
                       : (lo ? MSGSET_NMEA_REDUCED : MSGSET_BIN_NAV);
        c.baud         = hi ? (lo ? BAUD_9600 : BAUD_38400)
                       : (lo ? BAUD_4800 : BAUD_57600);
        c.usb_self_pwr = hi & ~lo;
        c.pwr          = pm ? PWR_MAX_PERF : PWR_ECO;
        return c;
    endfunction : strap_cfg
    task automatic chk(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    // reset held 10 cycles with the given straps
    task automatic boot(input logic hi, lo, pm);
        @(negedge clock_in);
        nrst_in = 1'b0;
        {s_hi, s_lo, s_pm} = {hi, lo, pm};
        repeat (10) @(negedge clock_in);
        nrst_in = 1'b1;
        repeat (6) @(negedge clock_in);
    endtask : boot
    task automatic send_exp(input ghpbc_field_t f, input logic [15:0] w);
        exp_q.push_back(cur);
        host.send(f, w, 0);
    endtask : send_exp

    // sampled after each rising edge, when outputs have settled
    always @(posedge clock_in) begin
        #2;
        if (cfg_ready && (!prev_rdy || cfg !== prev_cfg)) begin
            if (exp_q.size() == 0) chk("cfg change", 32'h0, 32'h1);
            else chk("cfg", 32'(exp_q.pop_front()), 32'(cfg));
        end
        prev_rdy = cfg_ready;
        prev_cfg = cfg;
    end
    // a hang ends the run as a mismatch
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        {nrst_in, bckp_nrst_in, fix_valid, s_lo, s_hi, s_pm} = 6'h0F;
        sats     = 6'h3F;
        sect_req = 4'h0;
        seed     = 32'h0001_6829;
        repeat (2) @(negedge clock_in);
        bckp_nrst_in = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cur = strap_cfg(i[1], i[0], i[0]);
            exp_q.push_back(cur);
            boot(i[1], i[0], i[0]);
        end
        {s_hi, s_lo, s_pm} = 3'h0;
        repeat (4) @(negedge clock_in);
        chk("acq", 32'h1, 32'(acq));
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            v    = (seed[15:0] == cur.baud) ? ~seed[15:0] : seed[15:0];
            cur.baud = v;
            exp_q.push_back(cur);
            host.send(FLD_BAUD, v, i % 2);
        end
        cur.proto_out = OUT_LEGAL;
        send_exp(FLD_PROTO_OUT, 16'h0007);
        cur.proto_in = 3'h5;
        send_exp(FLD_PROTO_IN, 16'h0005);
        host.send(FLD_PWR, 16'h0003, 0);
        host.send(FLD_SAVE, 16'h0000, 0);
        host.idle();
        repeat (3) @(negedge clock_in);
        chk("tx_en", 32'h0DB, 32'(tx_en));
        chk("rx_en", 32'h16D, 32'(rx_en));
        saved = cur;
        cur.baud = ~cur.baud;
        send_exp(FLD_BAUD, cur.baud);
        host.idle();
        cur = saved;
        exp_q.push_back(cur);
        boot(1'b0, 1'b0, 1'b0);
        chk("from_backup", 32'h1, 32'(from_bk));
        bckp_nrst_in = 1'b0;
        @(negedge clock_in);
        bckp_nrst_in = 1'b1;
        cur = strap_cfg(1'b0, 1'b0, 1'b0);
        exp_q.push_back(cur);
        boot(1'b0, 1'b0, 1'b0);
        chk("from_backup", 32'h0, 32'(from_bk));
        sats = 6'h04;
        repeat (2) @(negedge clock_in);
        chk("acq", 32'h0, 32'(acq));
        fix_valid = 1'b0;
        repeat (2) @(negedge clock_in);
        chk("acq", 32'h1, 32'(acq));
        seed     = lfsr(seed);
        sect_req = seed[3:0];
        cur.pwr  = PWR_SAVE;
        send_exp(FLD_PWR, 16'h0002);
        host.idle();
        repeat (3) @(negedge clock_in);
        chk("sections", 32'(sect_req), 32'(sect_en));
        repeat (2100) @(negedge clock_in);
        chk("queue left", 32'h0, 32'(exp_q.size()));
        results();
    end
endmodule : tb

bind ghpbc_boot_config ghpbc_boot_config_checker #(
    .ECO_MIN_SATS(ECO_MIN_SATS)
) chk_i (.clock_in, .nrst_in, .power_mode_strap_in, .fix_valid_in,
    .sats_tracked_in, .cfg_out, .cfg_ready_out, .cfg_from_backup_out,
    .acq_engine_en_out, .port_tx_en_out, .port_rx_en_out,
    .usb_plus_line_pullup_out, .spi_bit_tick_out);
